// ==== hw/par_check.sv ====
// par_check: matrix parity check and single bit repair of a whole image.
// assumes a settled image at its input; purely combinational.
`timescale 1ns/1ns
module par_check (
   // image as read from the nonvolatile cells
   input wire tcomp_pkg::mem_t image_i,
   // repaired image and verdict
   output tcomp_pkg::mem_t fixed_o,
   output logic corrected_o,
   output logic uncorr_o
);
   import tcomp_pkg::*;
   logic [COLS-1:0] synd;
   logic [1:0] nbad;
   logic [3:0] badrow;
   logic fixable;

   // row count over the 15 data rows, column syndrome over all 160 cells
   always_comb begin
      synd = COL_ODD;
      nbad = 2'h0;
      badrow = 4'h0;
      for (int r = 0; r < ROWS; r++) begin
         synd = synd ^ image_i[r];
         if (r < DATA_ROWS && !(^image_i[r])) begin
            badrow = 4'(r);
            if (nbad != 2'h2) nbad = nbad + 2'h1;
         end
      end
      // one bad row and one bad column pin the cell down
      fixable = (nbad == 2'h1) && $onehot(synd);
      fixed_o = image_i;
      if (fixable) fixed_o[badrow] = image_i[badrow] ^ synd;
      corrected_o = fixable;
      // a lone column hit is the parity row itself and is harmless
      uncorr_o = !fixable && (nbad != 2'h0 || !$onehot0(synd));
   end
endmodule

// ==== hw/sens_mult.sv ====
// sens_mult: second order temperature sensitivity factor and the product
// of field sample and factor, saturated to the sample width.
// assumes codes stay steady between samples; one cycle of latency.
`timescale 1ns/1ns
module sens_mult (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // codes, samples and result
   comp_if.dsp c
);
   import tcomp_pkg::*;
   typedef struct packed {
      logic signed [TEMP_W-1:0] temp;
      logic signed [SAMPLE_W-1:0] result;
      logic valid;
   } mult_st_t;
   mult_st_t st_ff;
   mult_st_t nxt_st;
   logic signed [10:0] lin;
   logic signed [9:0] quad;
   logic signed [TEMP_W-1:0] t0;
   logic signed [TEMP_W:0] dt;
   logic signed [31:0] factor;
   logic signed [47:0] scaled;

   // integer arithmetic only, so the host can predict every bit
   always_comb begin
      lin = $signed(11'(c.linear_coef_code)) - 11'(TL_BIAS);
      quad = $signed(10'(c.quadratic_coef_code)) - 10'(TQ_BIAS);
      t0 = $signed(TEMP_W'(c.ref_temp_code) << T0_SH)
         - TEMP_W'(T0_OFS);
      dt = (TEMP_W+1)'(st_ff.temp) - (TEMP_W+1)'(t0);
      factor = (32'sd1 <<< FRAC) + ((32'(lin) * 32'(dt)) <<< TL_SH)
         + 32'(quad) * 32'(dt) * 32'(dt);
      scaled = (48'(c.field) * 48'(factor)) >>> FRAC;
      nxt_st = st_ff;
      nxt_st.valid = c.field_valid;
      if (c.temp_valid) nxt_st.temp = c.temp;
      if (c.field_valid) begin
         if (c.fault) nxt_st.result = OUT_MAX;
         else if (scaled > 48'(OUT_MAX)) nxt_st.result = OUT_MAX;
         else if (scaled < 48'(OUT_MIN)) nxt_st.result = OUT_MIN;
         else nxt_st.result = SAMPLE_W'(scaled);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) st_ff <= '0;
      else st_ff <= nxt_st;
   end

   assign c.result = st_ff.result;
   assign c.result_valid = st_ff.valid;

   a_fault_full: assert property (
      @(posedge clk_i) disable iff (reset_i)
      c.field_valid && c.fault |=> c.result_valid && c.result == OUT_MAX)
      else $error("fault did not force full scale");
   a_ref_unity: assert property (
      @(posedge clk_i) disable iff (reset_i)
      c.field_valid && !c.fault && dt == '0 |=> c.result == $past(c.field))
      else $error("factor not one at reference temperature");
endmodule

// ==== hw/temp_comp.sv ====
// temp_comp: protected calibration memory with RAM working copy,
// redundant lock and timed nonvolatile commit, feeding the temperature
// sensitivity multiplier that scales each field sample.
// assumes the two-wire link decoder sits outside on clk_i and hands over
// whole commands on prog_*; temperature and field come from logic on
// clk_i, so none of them is resynchronised here.
`timescale 1ns/1ns
module temp_comp #(
   // factory image and programming phase lengths in clock cycles
   parameter tcomp_pkg::mem_t NVM_INIT = tcomp_pkg::factory(),
   parameter int unsigned ERASE_CYC = tcomp_pkg::ERASE_CYC_DEF,
   parameter int unsigned WRITE_CYC = tcomp_pkg::WRITE_CYC_DEF,
   parameter int unsigned SETTLE_CYC = tcomp_pkg::SETTLE_CYC_DEF
) (
   // clock, reset and power-on
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic por_i,
   // programming commands from the link decoder
   input wire logic prog_valid_i,
   input var tcomp_pkg::prog_op_t prog_op_i,
   input wire logic [3:0] prog_row_i,
   input wire logic [tcomp_pkg::COLS-1:0] prog_wdata_i,
   output logic prog_ack_o,
   output logic [tcomp_pkg::COLS-1:0] prog_rdata_o,
   output logic prog_busy_o,
   // samples in, compensated output
   input wire logic signed [tcomp_pkg::TEMP_W-1:0] temp_i,
   input wire logic temp_valid_i,
   input wire logic signed [tcomp_pkg::SAMPLE_W-1:0] field_i,
   input wire logic field_valid_i,
   output logic signed [tcomp_pkg::SAMPLE_W-1:0] out_o,
   output logic out_valid_o,
   // status
   output logic locked_o,
   output logic fault_o,
   output logic corrected_o,
   output logic ready_o
);
   import tcomp_pkg::*;

   typedef struct packed {
      state_t state;
      logic [CNT_W-1:0] cnt;
      mem_t ram;
      mem_t nvm;
      logic fault;
      logic corrected;
      logic [COLS-1:0] rdata;
      logic ack;
   } ctl_st_t;

   localparam ctl_st_t CTL_RST = '{state: ST_RESET, cnt: '0, ram: '0,
      nvm: '0, fault: 1'b0, corrected: 1'b0, rdata: '0, ack: 1'b0};
   localparam logic [CNT_W-1:0] ERASE_END = CNT_W'(ERASE_CYC - 1);
   localparam logic [CNT_W-1:0] WRITE_END = CNT_W'(WRITE_CYC - 1);
   localparam logic [CNT_W-1:0] SETTLE_END = CNT_W'(SETTLE_CYC - 1);

   ctl_st_t st_ff;
   ctl_st_t nxt_st;
   mem_t fixed;
   logic fix_ok;
   logic uncorr;
   logic locked;
   logic take;
   logic [COLS-1:0] rd_word;
   logic [COLS-1:0] col_sum;
   logic rows_odd;

   comp_if cif ();

   // checker sees the cells directly, so a single bad cell in a data row is repaired on every load
   par_check u_par (
      .image_i(st_ff.nvm),
      .fixed_o(fixed),
      .corrected_o(fix_ok),
      .uncorr_o(uncorr)
   );

   sens_mult u_mult (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .c(cif.dsp)
   );

   // either redundant bit alone freezes the part, so one weak cell
   // cannot reopen programming
   assign locked = |st_ff.nvm[LOCK_ROW][LOCK_W-1:0];

   // commands are only taken while running and unlocked
   assign take = prog_valid_i && st_ff.state == ST_RUN
      && !locked;
   assign rd_word = st_ff.ram[prog_row_i];

   // next state of the memory controller
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      case (st_ff.state)
         ST_LOAD: begin
            // repair happens on the way into the working copy
            nxt_st.ram = fixed;
            nxt_st.fault = uncorr;
            nxt_st.corrected = fix_ok;
            nxt_st.state = ST_RUN;
         end
         ST_RUN: begin
            nxt_st.cnt = '0;
            if (take) begin
               nxt_st.ack = 1'b1;
               case (prog_op_i)
                  OP_READ: begin
                     nxt_st.rdata = rd_word;
                  end
                  OP_WRITE: begin
                     // trial setups live only in RAM until commit
                     nxt_st.ram[prog_row_i] = prog_wdata_i;
                  end
                  OP_COMMIT: begin
                     nxt_st.state = ST_ERASE;
                  end
                  OP_RELOAD: begin
                     nxt_st.state = ST_LOAD;
                  end
                  default: begin
                     nxt_st.ack = 1'b0;
                  end
               endcase
            end
         end
         ST_ERASE: begin
            // erase pulse clears every cell at its end
            if (st_ff.cnt == ERASE_END) begin
               nxt_st.nvm = '0;
               nxt_st.cnt = '0;
               nxt_st.state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            // whole image lands in one write pulse: one cycle of wear
            if (st_ff.cnt == WRITE_END) begin
               nxt_st.nvm = st_ff.ram;
               nxt_st.cnt = '0;
               nxt_st.state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // pads the sequence to the minimum programming time
            if (st_ff.cnt == SETTLE_END) begin
               nxt_st.cnt = '0;
               nxt_st.state = ST_LOAD;
            end
         end
         default: begin
            nxt_st.state = ST_RESET;
         end
      endcase
   end

   // reset keeps the cells; only power-on restores the factory image
   always_ff @(posedge clk_i) begin
      if (reset_i || por_i) begin
         st_ff <= CTL_RST;
         st_ff.nvm <= por_i ? NVM_INIT : st_ff.nvm;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // coefficient codes come from the working copy only
   assign cif.linear_coef_code = st_ff.ram[TL_ROW][TL_W-1:0];
   assign cif.quadratic_coef_code = st_ff.ram[TQ_ROW][TQ_W-1:0];
   assign cif.ref_temp_code = st_ff.ram[TR_ROW][TR_W-1:0];
   assign cif.fault = st_ff.fault;

   // samples pass straight to the multiplier
   assign cif.temp = temp_i;
   assign cif.temp_valid = temp_valid_i;
   assign cif.field = field_i;
   assign cif.field_valid = field_valid_i;

   // outputs
   assign out_o = cif.result;
   assign out_valid_o = cif.result_valid;
   assign prog_ack_o = st_ff.ack;
   assign prog_rdata_o = st_ff.rdata;
   assign prog_busy_o = st_ff.state != ST_RUN;
   assign ready_o = st_ff.state == ST_RUN;
   assign locked_o = locked;
   assign fault_o = st_ff.fault;
   assign corrected_o = st_ff.corrected;

   // parity sums of the working copy, for checking only
   always_comb begin
      col_sum = COL_ODD;
      rows_odd = 1'b1;
      for (int r = 0; r < ROWS; r++) begin
         col_sum = col_sum ^ st_ff.ram[r];
         if (r < DATA_ROWS && !(^st_ff.ram[r])) rows_odd = 1'b0;
      end
   end

   a_load_to_run: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_LOAD |=> st_ff.state == ST_RUN
         && st_ff.ram == $past(fixed))
      else $error("load did not hand repaired image to run");

   a_row_odd: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_LOAD && !uncorr |=> rows_odd)
      else $error("loaded row has even parity");

   a_col_parity: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_LOAD && !uncorr |=> col_sum == '0)
      else $error("loaded columns break column parity");

   a_fault_flag: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_LOAD |=> fault_o == $past(uncorr))
      else $error("fault flag does not follow the load verdict");

   a_lock_freeze: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      locked && st_ff.state == ST_RUN |=> st_ff.state == ST_RUN
         && $stable(st_ff.ram) && $stable(st_ff.nvm))
      else $error("locked memory changed");

   a_lock_no_ack: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      locked && prog_valid_i |=> !prog_ack_o)
      else $error("locked part answered a command");

   a_write_lands: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      take && prog_op_i == OP_WRITE |=> prog_ack_o
         && st_ff.ram[$past(prog_row_i)] == $past(prog_wdata_i))
      else $error("RAM write lost");

   a_read_back: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      take && prog_op_i == OP_READ |=> prog_ack_o
         && prog_rdata_o == $past(rd_word))
      else $error("read returned wrong row");

   a_erase_end: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_ERASE && st_ff.cnt == ERASE_END
         |=> st_ff.state == ST_WRITE && st_ff.nvm == '0)
      else $error("erase pulse did not clear cells on time");

   a_write_end: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_WRITE && st_ff.cnt == WRITE_END
         |=> st_ff.state == ST_SETTLE && st_ff.nvm == $past(st_ff.ram))
      else $error("write pulse did not store the RAM image");

   a_cnt_bound: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_ERASE |-> st_ff.cnt <= ERASE_END)
      else $error("erase counter overran its pulse");

   a_settle_end: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      st_ff.state == ST_SETTLE && st_ff.cnt == SETTLE_END
         |=> st_ff.state == ST_LOAD)
      else $error("settle phase did not end in a load");

   a_busy_no_ack: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      prog_valid_i && st_ff.state != ST_RUN |=> !prog_ack_o)
      else $error("busy part answered a command");

   a_reload_load: assert property (
      @(posedge clk_i) disable iff (reset_i || por_i)
      take && prog_op_i == OP_RELOAD |=> prog_ack_o
         && st_ff.state == ST_LOAD)
      else $error("reload did not restart the load");
endmodule

// ==== include/comp_if.sv ====
// comp_if: coefficient codes, samples and result passed between the
// memory controller and the sensitivity multiplier.
// assumes both ends run on the same clock.
`timescale 1ns/1ns
interface comp_if;
   import tcomp_pkg::*;
   logic [TL_W-1:0] linear_coef_code;
   logic [TQ_W-1:0] quadratic_coef_code;
   logic [TR_W-1:0] ref_temp_code;
   logic signed [TEMP_W-1:0] temp;
   logic temp_valid;
   logic signed [SAMPLE_W-1:0] field;
   logic field_valid;
   logic fault;
   logic signed [SAMPLE_W-1:0] result;
   logic result_valid;
   modport ctl (output linear_coef_code, quadratic_coef_code,
      ref_temp_code, temp, temp_valid, field, field_valid, fault,
      input result, result_valid);
   modport dsp (input linear_coef_code, quadratic_coef_code,
      ref_temp_code, temp, temp_valid, field, field_valid, fault,
      output result, result_valid);
endinterface

// ==== include/tcomp_pkg.sv ====
// tcomp_pkg: constants and types shared by the temperature compensation
// block, its parity checker and its sensitivity multiplier.
// assumes a 100 MHz clock and a 16 row by 10 column calibration array.
package tcomp_pkg;
   // array shape: 15 data rows of 9 bits plus row parity, one parity row
   localparam int ROWS = 16;
   localparam int COLS = 10;
   localparam int DATA_ROWS = 15;
   localparam int RP_BIT = 9;
   localparam logic [3:0] CP_ROW = 4'hf;
   localparam logic [COLS-1:0] COL_ODD = 10'h2aa;
   // where coefficient codes and lock bits sit
   localparam logic [3:0] TL_ROW = 4'h0;
   localparam logic [3:0] TQ_ROW = 4'h1;
   localparam logic [3:0] TR_ROW = 4'h2;
   localparam logic [3:0] LOCK_ROW = 4'he;
   localparam int LOCK_W = 2;
   localparam int TL_W = 9;
   localparam int TQ_W = 8;
   localparam int TR_W = 3;
   // factory codes: unity factor, reference at 0 degrees
   localparam logic [TL_W-1:0] TL_RST = 9'h0a0;
   localparam logic [TQ_W-1:0] TQ_RST = 8'h80;
   localparam logic [TR_W-1:0] TR_RST = 3'h3;
   // code decoding; the factor is fixed point with 2^23 as one
   localparam int TL_BIAS = 160;
   localparam int TQ_BIAS = 128;
   localparam int T0_OFS = 48;
   localparam int T0_SH = 4;
   localparam int FRAC = 23;
   localparam int TL_SH = 7;
   localparam int SAMPLE_W = 16;
   localparam int TEMP_W = 9;
   localparam logic signed [SAMPLE_W-1:0] OUT_MAX = 16'sh7fff;
   localparam logic signed [SAMPLE_W-1:0] OUT_MIN = 16'sh8000;
   // nonvolatile programming timing
   localparam int CLK_MHZ = 100;
   localparam int ERASE_MS = 80;
   localparam int WRITE_MS = 10;
   localparam int PRG_MS = 100;
   localparam int CNT_W = 24;
   localparam int ERASE_CYC_DEF = ERASE_MS * 1000 * CLK_MHZ;
   localparam int WRITE_CYC_DEF = WRITE_MS * 1000 * CLK_MHZ;
   localparam int SETTLE_CYC_DEF =
      (PRG_MS - ERASE_MS - WRITE_MS) * 1000 * CLK_MHZ;

   typedef logic [ROWS-1:0][COLS-1:0] mem_t;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_COMMIT, OP_RELOAD}
      prog_op_t;
   typedef enum logic [2:0] {ST_LOAD, ST_RUN, ST_ERASE, ST_WRITE,
      ST_SETTLE} state_t;
   localparam state_t ST_RESET = ST_LOAD;

   // fill row parity and the column parity row of an image
   function automatic mem_t seal(input mem_t m);
      mem_t s;
      logic [COLS-1:0] col;
      s = m;
      col = COL_ODD;
      for (int r = 0; r < DATA_ROWS; r++) begin
         s[r][RP_BIT] = ~^s[r][RP_BIT-1:0];
         col = col ^ s[r];
      end
      s[CP_ROW] = col;
      return s;
   endfunction

   // factory image as left by pre-calibration
   function automatic mem_t factory();
      mem_t m;
      m = '0;
      m[TL_ROW][TL_W-1:0] = TL_RST;
      m[TQ_ROW][TQ_W-1:0] = TQ_RST;
      m[TR_ROW][TR_W-1:0] = TR_RST;
      return seal(m);
   endfunction
endpackage

// ==== tb/prog_model.sv ====
// prog_model: calibration programmer driving the temp_comp command port.
// assumes commands are issued only while the device reports ready.
`timescale 1ns/1ns
module prog_model (
   // clock and answers
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [tcomp_pkg::COLS-1:0] rdata_i,
   // command request
   output logic valid_o,
   output tcomp_pkg::prog_op_t op_o,
   output logic [3:0] row_o,
   output logic [tcomp_pkg::COLS-1:0] wdata_o
);
   import tcomp_pkg::*;
   mem_t img;
   int commits;
   initial begin
      valid_o = 1'b0;
      op_o = OP_READ;
      row_o = 4'h0;
      wdata_o = '0;
      img = '0;
      commits = 0;
   end
   // one command per high cycle; the registered answer stands from the
   // take edge to the next one, so it is read at the falling edge between.
   // commands carry no device address, so sensors on shared lines all
   // take the same command together
   task automatic cmd(input prog_op_t op, input logic [3:0] row,
      input logic [COLS-1:0] wd, output logic [COLS-1:0] rd,
      output logic ok);
      @(negedge clk_i);
      valid_o = 1'b1;
      op_o = op;
      row_o = row;
      wdata_o = wd;
      @(negedge clk_i);
      ok = ack_i;
      rd = rdata_i;
      valid_o = 1'b0;
      wdata_o = ~wd;
   endtask
   // factory area is read back before any parity is rebuilt
   task automatic fetch();
      logic ok;
      for (int r = 0; r < ROWS; r++) begin
         cmd(OP_READ, 4'(r), '0, img[r], ok);
      end
   endtask
   // row parity odd, column parity rebuilt over every data row
   task automatic put(input logic [3:0] row, input logic [8:0] d);
      logic [COLS-1:0] col;
      logic [COLS-1:0] rd;
      logic ok;
      img[row] = {~^d, d};
      col = COL_ODD;
      for (int r = 0; r < DATA_ROWS; r++) begin
         col = col ^ img[r];
      end
      img[CP_ROW] = col;
      cmd(OP_WRITE, row, img[row], rd, ok);
      cmd(OP_WRITE, CP_ROW, col, rd, ok);
   endtask
   // coefficients move as offsets from the factory codes
   task automatic trim(input logic [3:0] row, input int delta);
      put(row, img[row][8:0] + 9'(delta));
   endtask
   // endurance budget guarded here, not in the device
   task automatic commit(output logic ok);
      logic [COLS-1:0] rd;
      ok = 1'b0;
      if (commits < 10) begin
         commits++;
         cmd(OP_COMMIT, 4'h0, '0, rd, ok);
      end
   endtask
endmodule

// ==== tb/temp_comp_bench.sv ====
// temp_comp_bench: self-checking bench for temp_comp with short timing.
// assumes the factory image default and one 100 MHz clock.
`timescale 1ns/1ns
module temp_comp_bench;
   import tcomp_pkg::*;
   localparam int E = 8;
   localparam int W = 4;
   localparam int S = 3;
   logic clk_i, reset_i, por_i, temp_valid_i, field_valid_i;
   logic signed [TEMP_W-1:0] temp_i;
   logic signed [SAMPLE_W-1:0] field_i, out_o;
   logic prog_valid_i, prog_ack_o, prog_busy_o, out_valid_o;
   logic locked_o, fault_o, corrected_o, ready_o, ok;
   prog_op_t prog_op_i;
   logic [3:0] prog_row_i;
   logic [COLS-1:0] prog_wdata_i, prog_rdata_o, rd;
   int errors, checks, tl, tq, tr, n;
   int tt[3] = '{25, -40, 100};
   int ff[3] = '{1000, 32000, -32000};

   temp_comp #(.ERASE_CYC(E), .WRITE_CYC(W), .SETTLE_CYC(S)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .por_i(por_i),
      .prog_valid_i(prog_valid_i), .prog_op_i(prog_op_i),
      .prog_row_i(prog_row_i), .prog_wdata_i(prog_wdata_i),
      .prog_ack_o(prog_ack_o), .prog_rdata_o(prog_rdata_o),
      .prog_busy_o(prog_busy_o), .temp_i(temp_i),
      .temp_valid_i(temp_valid_i), .field_i(field_i),
      .field_valid_i(field_valid_i), .out_o(out_o),
      .out_valid_o(out_valid_o), .locked_o(locked_o), .fault_o(fault_o),
      .corrected_o(corrected_o), .ready_o(ready_o));
   prog_model pm (.clk_i(clk_i), .ack_i(prog_ack_o),
      .rdata_i(prog_rdata_o), .valid_o(prog_valid_i), .op_o(prog_op_i),
      .row_o(prog_row_i), .wdata_o(prog_wdata_i));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // full product in 64 bits, floored shift, then saturation
   function automatic logic [15:0] exp_out(input int t, input int f);
      longint dt, fac, p;
      dt = longint'(t) - longint'(16 * tr - 48);
      fac = (64'sd1 <<< 23) + ((longint'(tl - 160) * dt) <<< 7)
         + longint'(tq - 128) * dt * dt;
      p = (longint'(f) * fac) >>> 23;
      if (p > 32767) p = 32767;
      if (p < -32768) p = -32768;
      return p[15:0];
   endfunction
   task automatic sample(input int t, input int f, input logic [15:0] e);
      @(negedge clk_i);
      temp_i = t[TEMP_W-1:0];
      temp_valid_i = 1'b1;
      @(negedge clk_i);
      temp_valid_i = 1'b0;
      field_i = f[SAMPLE_W-1:0];
      field_valid_i = 1'b1;
      @(negedge clk_i);
      // result stands for one cycle after the sample edge
      field_valid_i = 1'b0;
      chk("out_valid", 16'h1, {15'h0, out_valid_o});
      chk("out", e, out_o);
   endtask
   // bounded wait, n counts edges until ready
   task automatic wait_ready();
      n = 0;
      while (ready_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask
   task automatic restart(input logic power);
      @(negedge clk_i);
      reset_i = 1'b1;
      por_i = power;
      repeat (2) @(negedge clk_i);
      reset_i = 1'b0;
      por_i = 1'b0;
      wait_ready();
   endtask
   task automatic wr(input logic [3:0] r, input logic [COLS-1:0] v);
      pm.cmd(OP_WRITE, r, v, rd, ok);
      chk("write ack", 16'h1, {15'h0, ok});
   endtask
   task automatic commit_wait();
      pm.commit(ok);
      chk("commit ack", 16'h1, {15'h0, ok});
      chk("busy", 16'h1, {15'h0, prog_busy_o});
      wait_ready();
      chk("commit cycles", 16'(E + W + S + 1), 16'(n));
   endtask
   task automatic status(input logic f, input logic c, input logic l);
      chk("fault", {15'h0, f}, {15'h0, fault_o});
      chk("corrected", {15'h0, c}, {15'h0, corrected_o});
      chk("locked", {15'h0, l}, {15'h0, locked_o});
   endtask

   initial begin
      errors = 0;
      checks = 0;
      temp_valid_i = 1'b0;
      field_valid_i = 1'b0;
      temp_i = '0;
      field_i = '0;
      reset_i = 1'b0;
      por_i = 1'b0;
      restart(1'b1);
      status(1'b0, 1'b0, 1'b0);
      pm.fetch();
      chk("tl", 16'(TL_RST), 16'(pm.img[0][8:0]));
      chk("tq", 16'(TQ_RST), 16'(pm.img[1][7:0]));
      chk("tr", 16'(TR_RST), 16'(pm.img[2][2:0]));
      for (int r = 0; r < 15; r++) begin
         chk("row parity", 16'h1, {15'h0, ^pm.img[r]});
      end
      rd = '0;
      for (int r = 0; r < 16; r++) rd = rd ^ pm.img[r];
      chk("column parity", 16'h2aa, 16'(rd));
      tl = TL_RST;
      tq = TQ_RST;
      tr = TR_RST;
      sample(25, 1000, exp_out(25, 1000));
      pm.trim(TL_ROW, 256);
      pm.trim(TQ_ROW, 16);
      pm.trim(TR_ROW, 1);
      tl = tl + 256;
      tq = tq + 16;
      tr = tr + 1;
      foreach (tt[i]) begin
         foreach (ff[j]) begin
            sample(tt[i], ff[j], exp_out(tt[i], ff[j]));
         end
      end
      sample(25, 1000, exp_out(25, 1000));
      // at the reference temperature the factor is exactly one
      sample(16, 1000, exp_out(16, 1000));
      commit_wait();
      restart(1'b0);
      pm.cmd(OP_READ, TL_ROW, '0, rd, ok);
      chk("kept row", 16'(pm.img[0]), 16'(rd));
      // one flipped data bit must be repaired on load
      wr(TR_ROW, pm.img[2] ^ 10'h010);
      commit_wait();
      status(1'b0, 1'b1, 1'b0);
      pm.cmd(OP_READ, TR_ROW, '0, rd, ok);
      chk("repaired row", 16'(pm.img[2]), 16'(rd));
      // a second bad row is beyond repair
      wr(TR_ROW, pm.img[2] ^ 10'h010);
      wr(TQ_ROW, pm.img[1] ^ 10'h001);
      commit_wait();
      status(1'b1, 1'b0, 1'b0);
      sample(25, 1000, 16'h7fff);
      wr(TR_ROW, pm.img[2]);
      wr(TQ_ROW, pm.img[1]);
      commit_wait();
      status(1'b0, 1'b0, 1'b0);
      // reload: one load cycle, then running again
      pm.cmd(OP_RELOAD, 4'h0, '0, rd, ok);
      chk("reload ack", 16'h1, {15'h0, ok});
      chk("reload busy", 16'h1, {15'h0, prog_busy_o});
      wait_ready();
      chk("reload cycles", 16'h1, 16'(n));
      // a command during the programming sequence is ignored
      pm.commit(ok);
      chk("commit ack", 16'h1, {15'h0, ok});
      pm.cmd(OP_READ, TL_ROW, '0, rd, ok);
      chk("busy ack", 16'h0, {15'h0, ok});
      wait_ready();
      status(1'b0, 1'b0, 1'b0);
      // freeze: both lock cells set, nothing may change afterwards
      pm.put(LOCK_ROW, 9'h003);
      commit_wait();
      status(1'b0, 1'b0, 1'b1);
      pm.cmd(OP_WRITE, TL_ROW, pm.img[0] ^ 10'h101, rd, ok);
      chk("locked ack", 16'h0, {15'h0, ok});
      pm.cmd(OP_COMMIT, 4'h0, '0, rd, ok);
      chk("locked ready", 16'h1, {15'h0, ready_o});
      restart(1'b0);
      status(1'b0, 1'b0, 1'b1);
      sample(-40, 1000, exp_out(-40, 1000));
      tally_and_finish();
   end
   // whole sequence needs well under 3000 cycles
   initial begin
      repeat (6000) @(posedge clk_i);
      errors++;
      tally_and_finish();
   end
endmodule
